// ==== verilog/hcu_dev.sv ====
// Contract
// - Four wires: rx, tx, rts, cts
// - Programmable baud 115200 to 1.5 Mbps
// - Typical and intermediate rates reachable
// - Baud changeable during traffic by command
// - Receiver tolerates combined 5 percent error
// - 1040-byte receive and transmit FIFOs
// - Traffic uses H4 packet framing
// - Reset baud is 115.2 kbaud
// - Device wake input wakes device
// - Host wake asserted while traffic pending, except in programming mode
// - Wake lines disabled until enabled
// - Same UART serves factory programming
// - Peripheral UART has 256-byte FIFOs; only PERI_FIFO_DEPTH is defined, no peripheral UART is built
// - Peripheral signals routable to P0-P39
`timescale 1ns/100ps
`default_nettype none
module hcu_dev import hcu_pkg::*; #(
	parameter int DEPTH = HCI_FIFO_DEPTH
) (
	input wire logic I_CLK,
	input wire logic I_RESET,
	hcu_link_if.dev link,
	input wire logic [7:0] I_TX_DATA,
	input wire logic I_TX_VALID,
	output logic O_TX_READY,
	output logic [7:0] O_RX_DATA,
	output logic O_RX_VALID,
	input wire logic I_RX_READY,
	output logic O_RX_ERROR,
	input wire logic [DIV_W-1:0] I_BAUD_DIV,
	input wire logic I_BAUD_LOAD,
	output logic [DIV_W-1:0] O_BAUD_DIV,
	input wire logic I_WAKE_EN,
	input wire logic I_EVENT_PENDING,
	output logic O_AWAKE,
	input wire logic I_PROG_MODE,
	output logic O_PROG_MODE,
	input wire logic I_ROUTE_EN,
	input wire logic [NUM_GPIO-1:0] I_GPIO_IN,
	input wire logic [GPIO_SEL_W-1:0] I_RX_SEL,
	input wire logic [GPIO_SEL_W-1:0] I_TX_SEL,
	output logic [NUM_GPIO-1:0] O_GPIO_OUT,
	output logic [NUM_GPIO-1:0] O_GPIO_OE
);
	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL = CW'(DEPTH);
	localparam logic [CW-1:0] RTS_LEVEL = CW'(DEPTH - RTS_MARGIN);

	logic [7:0] tx_mem [DEPTH];
	logic [7:0] rx_mem [DEPTH];
	logic [AW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
	logic [CW-1:0] tx_count, rx_count, next_tx_count, next_rx_count;
	logic tx_push, tx_pop, rx_push, rx_pop;
	logic [DIV_W-1:0] div;
	logic link_meta, link_sync, rx_sync, cts_meta, cts_n, wake_meta, wake_sync;
	logic [NUM_GPIO-1:0] gpio_meta, gpio_sync;
	hcu_bit_e tx_state, rx_state;
	logic [DIV_W-1:0] tx_cnt, rx_cnt;
	logic [2:0] tx_idx, rx_idx;
	logic [7:0] tx_sh, rx_sh;
	logic txd, rts_n, host_wake;

	function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
		return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
	endfunction

	// Pins synchronised before the mux, so a select change never meets metastability
	assign rx_sync = I_ROUTE_EN ? gpio_sync[I_RX_SEL] : link_sync;

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			link_meta <= 1'b1;
			link_sync <= 1'b1;
			gpio_meta <= '1;
			gpio_sync <= '1;
			cts_meta <= 1'b1;
			cts_n <= 1'b1;
			wake_meta <= 1'b0;
			wake_sync <= 1'b0;
		end else begin
			link_meta <= link.h2d_data;
			link_sync <= link_meta;
			gpio_meta <= I_GPIO_IN;
			gpio_sync <= gpio_meta;
			cts_meta <= link.h2d_rts_n;
			cts_n <= cts_meta;
			wake_meta <= link.device_wake_request;
			wake_sync <= wake_meta;
		end
	end

	// New rate takes effect at once; firmware issues it between packets
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			div <= DIV_DEFAULT;
		end else if (I_BAUD_LOAD) begin
			div <= hcu_clamp_div(I_BAUD_DIV);
		end
	end

	assign tx_push = I_TX_VALID && O_TX_READY;
	assign tx_pop = (tx_state == HCU_IDLE) && (tx_count != '0) && !cts_n;
	assign rx_pop = (rx_count != '0) && (!O_RX_VALID || I_RX_READY);

	always_comb begin
		next_tx_count = tx_count;
		if (tx_push && !tx_pop) begin
			next_tx_count = tx_count + 1'b1;
		end else if (tx_pop && !tx_push) begin
			next_tx_count = tx_count - 1'b1;
		end
		next_rx_count = rx_count;
		if (rx_push && !rx_pop) begin
			next_rx_count = rx_count + 1'b1;
		end else if (rx_pop && !rx_push) begin
			next_rx_count = rx_count - 1'b1;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (tx_push) begin
			tx_mem[tx_wp] <= I_TX_DATA;
		end
		if (rx_push) begin
			rx_mem[rx_wp] <= rx_sh;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			tx_wp <= '0;
			tx_rp <= '0;
			rx_wp <= '0;
			rx_rp <= '0;
			tx_count <= '0;
			rx_count <= '0;
			O_TX_READY <= 1'b0;
		end else begin
			if (tx_push) begin
				tx_wp <= ptr_inc(tx_wp);
			end
			if (tx_pop) begin
				tx_rp <= ptr_inc(tx_rp);
			end
			if (rx_push) begin
				rx_wp <= ptr_inc(rx_wp);
			end
			if (rx_pop) begin
				rx_rp <= ptr_inc(rx_rp);
			end
			tx_count <= next_tx_count;
			rx_count <= next_rx_count;
			O_TX_READY <= next_tx_count != FULL;
		end
	end

	// Bytes pass through untouched; H4 type bytes are parsed above
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			O_RX_VALID <= 1'b0;
			O_RX_DATA <= 8'h00;
		end else if (rx_pop) begin
			O_RX_VALID <= 1'b1;
			O_RX_DATA <= rx_mem[rx_rp];
		end else if (I_RX_READY) begin
			O_RX_VALID <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			tx_state <= HCU_IDLE;
			tx_cnt <= '0;
			tx_idx <= '0;
			tx_sh <= 8'h00;
			txd <= 1'b1;
		end else begin
			case (tx_state)
				HCU_IDLE: begin
					if (tx_pop) begin
						tx_sh <= tx_mem[tx_rp];
						txd <= 1'b0;
						tx_cnt <= div - 1'b1;
						tx_state <= HCU_START;
					end
				end
				HCU_START, HCU_DATA: begin
					if (tx_cnt != '0) begin
						tx_cnt <= tx_cnt - 1'b1;
					end else begin
						tx_cnt <= div - 1'b1;
						if (tx_state == HCU_START) begin
							txd <= tx_sh[0];
							tx_idx <= '0;
							tx_state <= HCU_DATA;
						end else if (tx_idx == LAST_BIT) begin
							txd <= 1'b1;
							tx_state <= HCU_STOP;
						end else begin
							txd <= tx_sh[tx_idx + 1'b1];
							tx_idx <= tx_idx + 1'b1;
						end
					end
				end
				HCU_STOP: begin
					if (tx_cnt != '0) begin
						tx_cnt <= tx_cnt - 1'b1;
					end else begin
						tx_state <= HCU_IDLE;
					end
				end
				default: begin
					tx_state <= HCU_IDLE;
					txd <= 1'b1;
				end
			endcase
		end
	end

	// Mid-bit sampling leaves half a bit of slack over ten bits
	assign rx_push = (rx_state == HCU_STOP) && (rx_cnt == '0) && rx_sync && (rx_count != FULL);

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			rx_state <= HCU_IDLE;
			rx_cnt <= '0;
			rx_idx <= '0;
			rx_sh <= 8'h00;
			O_RX_ERROR <= 1'b0;
		end else begin
			O_RX_ERROR <= 1'b0;
			case (rx_state)
				HCU_IDLE: begin
					if (!rx_sync) begin
						rx_cnt <= div >> 1;
						rx_state <= HCU_START;
					end
				end
				HCU_START: begin
					if (rx_cnt != '0) begin
						rx_cnt <= rx_cnt - 1'b1;
					end else if (!rx_sync) begin
						rx_cnt <= div - 1'b1;
						rx_idx <= '0;
						rx_state <= HCU_DATA;
					end else begin
						rx_state <= HCU_IDLE;
					end
				end
				HCU_DATA: begin
					if (rx_cnt != '0) begin
						rx_cnt <= rx_cnt - 1'b1;
					end else begin
						rx_cnt <= div - 1'b1;
						rx_sh <= {rx_sync, rx_sh[7:1]};
						rx_idx <= rx_idx + 1'b1;
						if (rx_idx == LAST_BIT) begin
							rx_state <= HCU_STOP;
						end
					end
				end
				HCU_STOP: begin
					if (rx_cnt != '0) begin
						rx_cnt <= rx_cnt - 1'b1;
					end else begin
						O_RX_ERROR <= !rx_sync || (rx_count == FULL);
						rx_state <= HCU_IDLE;
					end
				end
				default: begin
					rx_state <= HCU_IDLE;
				end
			endcase
		end
	end

	// Wake logic inert until the enabling command arrives
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			rts_n <= 1'b1;
			host_wake <= 1'b0;
			O_AWAKE <= 1'b1;
			O_PROG_MODE <= 1'b0;
			O_BAUD_DIV <= DIV_DEFAULT;
		end else begin
			rts_n <= next_rx_count >= RTS_LEVEL;
			host_wake <= I_WAKE_EN && !I_PROG_MODE &&
				(tx_count != '0 || I_EVENT_PENDING);
			O_AWAKE <= !I_WAKE_EN || wake_sync;
			O_PROG_MODE <= I_PROG_MODE;
			O_BAUD_DIV <= div;
		end
	end

	assign link.d2h_data = txd;
	assign link.d2h_rts_n = rts_n;
	assign link.host_wake = host_wake;

	for (genvar g = 0; g < NUM_GPIO; g++) begin : g_pin
		always_ff @(posedge I_CLK) begin
			if (I_RESET) begin
				O_GPIO_OUT[g] <= 1'b1;
				O_GPIO_OE[g] <= 1'b0;
			end else begin
				O_GPIO_OUT[g] <= txd;
				O_GPIO_OE[g] <= I_ROUTE_EN && (I_TX_SEL == GPIO_SEL_W'(g));
			end
		end
	end
endmodule // hcu_dev
`default_nettype wire

// ==== verilog/hcu_pkg.sv ====
`default_nettype none
package hcu_pkg;
	localparam int CLK_HZ = 200_000_000;
	localparam int BAUD_DEFAULT = 115_200;
	localparam int BAUD_MIN = 115_200;
	localparam int BAUD_MAX = 1_500_000;
	localparam int DIV_W = 16;
	localparam logic [DIV_W-1:0] DIV_DEFAULT = DIV_W'(CLK_HZ / BAUD_DEFAULT);
	localparam logic [DIV_W-1:0] DIV_MIN = DIV_W'(CLK_HZ / BAUD_MAX);
	localparam logic [DIV_W-1:0] DIV_MAX = DIV_W'(CLK_HZ / BAUD_MIN);
	localparam int HCI_FIFO_DEPTH = 1040;
	localparam int PERI_FIFO_DEPTH = 256;
	localparam int RTS_MARGIN = 16;
	localparam int NUM_GPIO = 40;
	localparam int GPIO_SEL_W = 6;
	localparam logic [2:0] LAST_BIT = 3'h7;
	typedef enum logic [3:0] {
		HCU_IDLE = 4'h1,
		HCU_START = 4'h2,
		HCU_DATA = 4'h4,
		HCU_STOP = 4'h8
	} hcu_bit_e;
	function automatic logic [DIV_W-1:0] hcu_clamp_div(input logic [DIV_W-1:0] d);
		if (d < DIV_MIN) begin
			return DIV_MIN;
		end
		if (d > DIV_MAX) begin
			return DIV_MAX;
		end
		return d;
	endfunction
endpackage
`default_nettype wire

// ==== verilog/hcu_link_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface hcu_link_if;
	logic h2d_data;
	logic d2h_data;
	logic d2h_rts_n;
	logic h2d_rts_n;
	logic device_wake_request;
	logic host_wake;
	modport dev(input h2d_data, h2d_rts_n, device_wake_request,
		output d2h_data, d2h_rts_n, host_wake);
	modport host(output h2d_data, h2d_rts_n, device_wake_request,
		input d2h_data, d2h_rts_n, host_wake);
endinterface
`default_nettype wire

// ==== verilog/hcu_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module hcu_host import hcu_pkg::*; (
	input wire logic I_CLK,
	input wire logic I_RESET,
	hcu_link_if.host link,
	input wire logic [7:0] I_TX_DATA,
	input wire logic I_TX_VALID,
	output logic O_TX_READY,
	output logic [7:0] O_RX_DATA,
	output logic O_RX_VALID,
	output logic O_RX_ERROR,
	input wire logic I_RX_HOLD,
	input wire logic [DIV_W-1:0] I_BAUD_DIV,
	input wire logic I_BAUD_LOAD,
	input wire logic I_WAKE_DEVICE,
	output logic O_HOST_WAKE
);
	logic [DIV_W-1:0] div;
	logic rx_meta, rx_sync, cts_meta, cts_n, hw_meta;
	hcu_bit_e tx_state, rx_state;
	logic [DIV_W-1:0] tx_cnt, rx_cnt;
	logic [2:0] tx_idx, rx_idx;
	logic [7:0] tx_sh, rx_sh;
	logic txd, rts_n, wake;

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			rx_meta <= 1'b1;
			rx_sync <= 1'b1;
			cts_meta <= 1'b1;
			cts_n <= 1'b1;
			hw_meta <= 1'b0;
			O_HOST_WAKE <= 1'b0;
			div <= DIV_DEFAULT;
			rts_n <= 1'b1;
			wake <= 1'b0;
		end else begin
			rx_meta <= link.d2h_data;
			rx_sync <= rx_meta;
			cts_meta <= link.d2h_rts_n;
			cts_n <= cts_meta;
			hw_meta <= link.host_wake;
			O_HOST_WAKE <= hw_meta;
			if (I_BAUD_LOAD) begin
				div <= hcu_clamp_div(I_BAUD_DIV);
			end
			rts_n <= I_RX_HOLD;
			wake <= I_WAKE_DEVICE;
		end
	end

	// One-byte holding stage; sender waits while the device drops RTS
	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			tx_state <= HCU_IDLE;
			tx_cnt <= '0;
			tx_idx <= '0;
			tx_sh <= 8'h00;
			txd <= 1'b1;
			O_TX_READY <= 1'b0;
		end else begin
			O_TX_READY <= (tx_state == HCU_IDLE) && !cts_n && !(I_TX_VALID && O_TX_READY);
			case (tx_state)
				HCU_IDLE: begin
					if (I_TX_VALID && O_TX_READY) begin
						tx_sh <= I_TX_DATA;
						txd <= 1'b0;
						tx_cnt <= div - 1'b1;
						tx_state <= HCU_START;
					end
				end
				HCU_START, HCU_DATA: begin
					if (tx_cnt != '0) begin
						tx_cnt <= tx_cnt - 1'b1;
					end else begin
						tx_cnt <= div - 1'b1;
						if (tx_state == HCU_START) begin
							txd <= tx_sh[0];
							tx_idx <= '0;
							tx_state <= HCU_DATA;
						end else if (tx_idx == LAST_BIT) begin
							txd <= 1'b1;
							tx_state <= HCU_STOP;
						end else begin
							txd <= tx_sh[tx_idx + 1'b1];
							tx_idx <= tx_idx + 1'b1;
						end
					end
				end
				HCU_STOP: begin
					if (tx_cnt != '0) begin
						tx_cnt <= tx_cnt - 1'b1;
					end else begin
						tx_state <= HCU_IDLE;
					end
				end
				default: begin
					tx_state <= HCU_IDLE;
					txd <= 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RESET) begin
			rx_state <= HCU_IDLE;
			rx_cnt <= '0;
			rx_idx <= '0;
			rx_sh <= 8'h00;
			O_RX_DATA <= 8'h00;
			O_RX_VALID <= 1'b0;
			O_RX_ERROR <= 1'b0;
		end else begin
			O_RX_VALID <= 1'b0;
			O_RX_ERROR <= 1'b0;
			case (rx_state)
				HCU_IDLE: begin
					if (!rx_sync) begin
						rx_cnt <= div >> 1;
						rx_state <= HCU_START;
					end
				end
				HCU_START: begin
					if (rx_cnt != '0) begin
						rx_cnt <= rx_cnt - 1'b1;
					end else if (!rx_sync) begin
						rx_cnt <= div - 1'b1;
						rx_idx <= '0;
						rx_state <= HCU_DATA;
					end else begin
						rx_state <= HCU_IDLE;
					end
				end
				HCU_DATA: begin
					if (rx_cnt != '0) begin
						rx_cnt <= rx_cnt - 1'b1;
					end else begin
						rx_cnt <= div - 1'b1;
						rx_sh <= {rx_sync, rx_sh[7:1]};
						rx_idx <= rx_idx + 1'b1;
						if (rx_idx == LAST_BIT) begin
							rx_state <= HCU_STOP;
						end
					end
				end
				HCU_STOP: begin
					if (rx_cnt != '0) begin
						rx_cnt <= rx_cnt - 1'b1;
					end else begin
						O_RX_VALID <= rx_sync;
						O_RX_ERROR <= !rx_sync;
						O_RX_DATA <= rx_sh;
						rx_state <= HCU_IDLE;
					end
				end
				default: begin
					rx_state <= HCU_IDLE;
				end
			endcase
		end
	end

	assign link.h2d_data = txd;
	assign link.h2d_rts_n = rts_n;
	assign link.device_wake_request = wake;
endmodule // hcu_host
`default_nettype wire

// ==== sim/hcu_link_chk.sv ====
`timescale 1ns/100ps
`default_nettype none
module hcu_link_chk import hcu_pkg::*; (
	input wire logic I_CLK,
	input wire logic I_RESET,
	input wire logic h2d_data,
	input wire logic d2h_data,
	input wire logic d2h_rts_n,
	input wire logic h2d_rts_n,
	input wire logic device_wake_request,
	input wire logic host_wake
);
	localparam logic [15:0] MAX_LOW = 16'(9 * DIV_MAX);
	logic [15:0] run_d;
	logic [15:0] run_h;
	logic prev_d;
	logic prev_h;
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (I_RESET);
	// Saturated in reset so the idle level never reads as a short bit
	always_ff @(posedge I_CLK) begin
		prev_d <= d2h_data;
		if (I_RESET) begin
			run_d <= 16'hFFFF;
		end else if (d2h_data != prev_d) begin
			run_d <= 16'h0001;
		end else if (run_d != 16'hFFFF) begin
			run_d <= run_d + 16'h0001;
		end
	end
	always_ff @(posedge I_CLK) begin
		prev_h <= h2d_data;
		if (I_RESET) begin
			run_h <= 16'hFFFF;
		end else if (h2d_data != prev_h) begin
			run_h <= 16'h0001;
		end else if (run_h != 16'hFFFF) begin
			run_h <= run_h + 16'h0001;
		end
	end
	property p_reset_idle;
		$fell(I_RESET) |-> d2h_data && h2d_data && d2h_rts_n && h2d_rts_n && !host_wake;
	endproperty
	a_reset_idle: assert property (p_reset_idle) else $error("link not idle after reset");
	property p_rts_open;
		$fell(I_RESET) |=> !d2h_rts_n;
	endproperty
	a_rts_open: assert property (p_rts_open) else $error("device rts not opened");
	property p_host_quiet;
		$fell(I_RESET) |-> h2d_data[*4];
	endproperty
	a_host_quiet: assert property (p_host_quiet) else $error("host sent before rts seen");
	property p_dev_quiet;
		$fell(I_RESET) |-> d2h_data[*3];
	endproperty
	a_dev_quiet: assert property (p_dev_quiet) else $error("device sent before cts seen");
	property p_d2h_bit_min;
		(d2h_data != prev_d) |-> run_d >= DIV_MIN;
	endproperty
	a_d2h_bit_min: assert property (p_d2h_bit_min) else $error("device bit too short");
	property p_h2d_bit_min;
		(h2d_data != prev_h) |-> run_h >= DIV_MIN;
	endproperty
	a_h2d_bit_min: assert property (p_h2d_bit_min) else $error("host bit too short");
	property p_d2h_low_max;
		(d2h_data && !prev_d) |-> run_d <= MAX_LOW;
	endproperty
	a_d2h_low_max: assert property (p_d2h_low_max) else $error("device line low too long");
	property p_h2d_low_max;
		(h2d_data && !prev_h) |-> run_h <= MAX_LOW;
	endproperty
	a_h2d_low_max: assert property (p_h2d_low_max) else $error("host line low too long");
endmodule // hcu_link_chk
`default_nettype wire

// ==== sim/hcu_bench.sv ====
`timescale 1ns/100ps
`default_nettype none
module hcu_bench import hcu_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] dtx_d = 8'h00, htx_d = 8'h00, drx_d, hrx_d;
	logic dtx_v = 0, htx_v = 0, drx_rdy = 1, hold = 0, dload = 0, hload = 0;
	logic wake_en = 0, ev = 1, prog = 0, route = 0, wdev = 0;
	logic dtx_rdy, htx_rdy, drx_v, hrx_v, drx_e, hrx_e, awake, prog_o, hwake;
	logic [DIV_W-1:0] ddiv = DIV_DEFAULT, hdiv = DIV_DEFAULT, ddiv_o;
	logic [NUM_GPIO-1:0] gin = '1, gout, goe;
	logic [GPIO_SEL_W-1:0] sel = '0;
	logic [15:0] divs[5] = '{16'h0010, 16'h0100, 16'hFFFF, 16'h00D9, 16'h06C8};
	logic [7:0] dq[$], hq[$], sent[$];
	int n_errors = 0, n_compared = 0, cycles = 0, n_rxerr = 0;
	hcu_link_if link();
	hcu_dev i_hcu_dev (.I_CLK(clk), .I_RESET(rst), .link(link), .I_TX_DATA(dtx_d),
		.I_TX_VALID(dtx_v), .O_TX_READY(dtx_rdy), .O_RX_DATA(drx_d), .O_RX_VALID(drx_v),
		.I_RX_READY(drx_rdy), .O_RX_ERROR(drx_e), .I_BAUD_DIV(ddiv), .I_BAUD_LOAD(dload),
		.O_BAUD_DIV(ddiv_o), .I_WAKE_EN(wake_en), .I_EVENT_PENDING(ev), .O_AWAKE(awake),
		.I_PROG_MODE(prog), .O_PROG_MODE(prog_o), .I_ROUTE_EN(route), .I_GPIO_IN(gin),
		.I_RX_SEL(sel), .I_TX_SEL(sel), .O_GPIO_OUT(gout), .O_GPIO_OE(goe));
	hcu_host i_hcu_host (.I_CLK(clk), .I_RESET(rst), .link(link), .I_TX_DATA(htx_d),
		.I_TX_VALID(htx_v), .O_TX_READY(htx_rdy), .O_RX_DATA(hrx_d), .O_RX_VALID(hrx_v),
		.O_RX_ERROR(hrx_e), .I_RX_HOLD(hold), .I_BAUD_DIV(hdiv), .I_BAUD_LOAD(hload),
		.I_WAKE_DEVICE(wdev), .O_HOST_WAKE(hwake));
	hcu_link_chk i_hcu_link_chk (.I_CLK(clk), .I_RESET(rst), .h2d_data(link.h2d_data),
		.d2h_data(link.d2h_data), .d2h_rts_n(link.d2h_rts_n), .h2d_rts_n(link.h2d_rts_n),
		.device_wake_request(link.device_wake_request), .host_wake(link.host_wake));
	always #2.5 clk = ~clk;
	// Random back-pressure on the device receive side
	always @(posedge clk) begin
		drx_rdy <= 1'($urandom);
		if (hrx_v === 1'b1) hq.push_back(hrx_d);
		if (drx_v === 1'b1 && drx_rdy === 1'b1) dq.push_back(drx_d);
		if (!rst && (drx_e === 1'b1 || hrx_e === 1'b1)) n_rxerr++;
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			$display("CHECK FAILED %0t timeout", $time);
			complete_run();
		end
	end
	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string what);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t %s", $time, what);
		end
	endtask
	function automatic logic [15:0] exp_div(input logic [15:0] d);
		return d < DIV_MIN ? DIV_MIN : (d > DIV_MAX ? DIV_MAX : d);
	endfunction
	task automatic set_baud(input logic [15:0] dd, input logic [15:0] hd);
		@(posedge clk);
		ddiv <= dd;
		hdiv <= hd;
		dload <= 1'b1;
		hload <= 1'b1;
		@(posedge clk);
		dload <= 1'b0;
		hload <= 1'b0;
		repeat (2) @(posedge clk);
		chk(40'(ddiv_o), 40'(exp_div(dd)), "divisor");
	endtask
	task automatic push(input bit from_host, input logic [7:0] b);
		@(posedge clk);
		if (from_host) begin
			htx_d <= b;
			htx_v <= 1'b1;
		end else begin
			dtx_d <= b;
			dtx_v <= 1'b1;
		end
		@(posedge clk);
		while ((from_host ? htx_rdy : dtx_rdy) !== 1'b1) @(posedge clk);
		htx_v <= 1'b0;
		dtx_v <= 1'b0;
	endtask
	task automatic xfer(input bit from_host, input int n);
		logic [7:0] b;
		int k;
		sent.delete();
		dq.delete();
		hq.delete();
		for (int i = 0; i < n; i++) begin
			b = i == 0 ? 8'h00 : (i == 1 ? 8'hFF : (i == 2 ? 8'h01 : 8'($urandom)));
			sent.push_back(b);
			push(from_host, b);
		end
		k = 0;
		while ((from_host ? dq.size() : hq.size()) < n && k < 20000) begin
			@(posedge clk);
			k++;
		end
		for (int i = 0; i < n; i++) begin
			chk(40'(from_host ? dq[i] : hq[i]), 40'(sent[i]), "byte");
		end
		$display("test xfer %0d done", from_host);
	endtask
	task automatic complete_run();
		$display("n_compared=%0d n_errors=%0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	initial begin
		void'($urandom(32'h756d_6166));
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		chk(40'(ddiv_o), 40'(DIV_DEFAULT), "reset baud");
		chk(40'(awake), 40'h1, "awake while disabled");
		chk(40'(hwake), 40'h0, "host wake while disabled");
		foreach (divs[i]) set_baud(divs[i], divs[i]);
		set_baud(DIV_MIN, DIV_MIN);
		xfer(0, 6);
		set_baud(DIV_MIN, 16'h008B);
		xfer(1, 6);
		hold <= 1'b1;
		repeat (6) @(posedge clk);
		push(0, 8'hA5);
		hq.delete();
		repeat (3000) @(posedge clk);
		chk(40'(hq.size()), 40'h0, "sent while held");
		hold <= 1'b0;
		repeat (3000) @(posedge clk);
		chk(40'(hq[0]), 40'h00_0000_00A5, "held byte");
		chk(40'(n_rxerr), 40'h0, "receive errors");
		$display("test flow done");
		wake_en <= 1'b1;
		ev <= 1'b0;
		repeat (8) @(posedge clk);
		chk(40'(awake), 40'h0, "device asleep");
		chk(40'(hwake), 40'h0, "host left asleep");
		ev <= 1'b1;
		wdev <= 1'b1;
		repeat (8) @(posedge clk);
		chk(40'(hwake), 40'h1, "host woken");
		chk(40'(awake), 40'h1, "device woken");
		prog <= 1'b1;
		repeat (8) @(posedge clk);
		chk(40'(hwake), 40'h0, "wake in prog");
		chk(40'(prog_o), 40'h1, "prog mode");
		$display("test wake done");
		route <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			sel <= i == 0 ? 6'h00 : (i == 1 ? 6'h27 : 6'($urandom % NUM_GPIO));
			repeat (4) @(posedge clk);
			chk(goe, 40'h00_0000_0001 << sel, "route enable");
			chk(40'(gout[sel]), 40'h1, "route idle");
		end
		$display("test route done");
		complete_run();
	end
endmodule // hcu_bench
`default_nettype wire
